//--- rtl/temp_conv_pkg.sv
// Shared constants and types of the temperature conversion controller.
package temp_conv_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and conversion timing.
    localparam int CLK_MHZ = 250;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int CONV_MS = 240;
    localparam int FAST_MS = 6;
    localparam int SPS_CONV_MS = 60;
    localparam int SPS_IDLE_MS = 940;
    localparam int WAKE_MS = 1;
    localparam int CONV_CYC = CONV_MS * CYC_PER_MS;
    localparam int FAST_CYC = FAST_MS * CYC_PER_MS;
    localparam int SPS_CONV_CYC = SPS_CONV_MS * CYC_PER_MS;
    localparam int SPS_IDLE_CYC = SPS_IDLE_MS * CYC_PER_MS;
    localparam int WAKE_CYC = WAKE_MS * CYC_PER_MS;
    localparam int TMR_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses.
    localparam logic [7:0] ADDR_TEMP_MSB = 8'h00;
    localparam logic [7:0] ADDR_TEMP_LSB = 8'h01;
    localparam logic [7:0] ADDR_CFG = 8'h03;
    localparam logic [7:0] ADDR_LIM_FIRST = 8'h04;
    localparam logic [7:0] ADDR_LIM_LAST = 8'h0a;
    localparam int LIM_BYTES = 7;

    // Limit bytes, index 0 at the first limit address.
    localparam int LIM_UP_MSB = 0;
    localparam int LIM_UP_LSB = 1;
    localparam int LIM_LO_MSB = 2;
    localparam int LIM_LO_LSB = 3;
    localparam int LIM_CR_MSB = 4;
    localparam int LIM_CR_LSB = 5;
    localparam int LIM_HYST = 6;
    localparam logic [LIM_BYTES-1:0][7:0] LIM_RESET =
        {8'h05, 8'h80, 8'h49, 8'h00, 8'h05, 8'h00, 8'h20};

    ////////////////////////////////////////////////////////////////////////
    // Configuration fields and result format.
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CFG_FQ_LSB = 0;
    localparam int CFG_FQ_W = 2;
    localparam int CFG_CRIT_POL = 2;
    localparam int CFG_INT_POL = 3;
    localparam int CFG_IRQ_MODE = 4;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_RES = 7;
    localparam int FLAG_LOW = 0;
    localparam int FLAG_HIGH = 1;
    localparam int FLAG_CRIT = 2;
    localparam int FLAG_W = 3;
    localparam int HYST_W = 4;

    typedef enum logic [1:0] {
        MODE_CONT = 2'h0,
        MODE_ONESHOT = 2'h1,
        MODE_SPS = 2'h2,
        MODE_SHDN = 2'h3
    } op_mode_t;

endpackage

//--- rtl/temp_conv_if.sv
// Interfaces between the controller and its timer and fault queues.
`timescale 1ns/1ps
`default_nettype none

interface tmr_if import temp_conv_pkg::*; ();
    logic start;
    logic [TMR_W-1:0] load;
    logic done;
    modport ctrl (output start, output load, input done);
    modport timer (input start, input load, output done);
endinterface

interface fq_if;
    logic eval;
    logic fault;
    logic [1:0] depth;
    logic trip;
    modport ctrl (output eval, output fault, output depth, input trip);
    modport queue (input eval, input fault, input depth, output trip);
endinterface

`default_nettype wire

//--- rtl/conv_timer.sv
// Down-counter that times wake-up, conversion and idle phases.
`timescale 1ns/1ps
`default_nettype none

module conv_timer import temp_conv_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    tmr_if.timer t
);
    logic [TMR_W-1:0] cnt_q, cnt_d;

    // A start reloads even while running, so an abort needs no extra path.
    always_comb begin
        cnt_d = cnt_q;
        if (t.start) begin
            cnt_d = t.load;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - TMR_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign t.done = (cnt_q == TMR_W'(1));
endmodule

`default_nettype wire

//--- rtl/fault_queue.sv
// Consecutive-fault counter for one alert output.
`timescale 1ns/1ps
`default_nettype none

module fault_queue (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    fq_if.queue f
);
    logic [1:0] cnt_q, cnt_d;
    logic trip;

    always_comb begin
        cnt_d = cnt_q;
        trip = 1'b0;
        if (f.eval) begin
            if (!f.fault) begin
                cnt_d = 2'h0;
            end else begin
                // The count saturates, so lowering the depth still trips.
                if (cnt_q >= f.depth) begin
                    trip = 1'b1;
                end
                if (cnt_q != '1) begin
                    cnt_d = cnt_q + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 2'h0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign f.trip = trip;

    a_queue_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        f.eval && !f.fault && ce |=> cnt_q == 2'h0)
        else $error("fault count not cleared by a good result");
    a_queue_depth: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        f.eval && f.fault && cnt_q < f.depth |-> !trip)
        else $error("alert tripped before the programmed fault count");
endmodule

`default_nettype wire

//--- rtl/temp_conv_ctrl.sv
// Conversion sequencing, limit alarms and register file of the sensor.
//
// How it works
// - Continuous mode runs 240 ms conversions back to back.
// - Every finished conversion is stored; reads return the latest result.
// - First conversion after power-up is a fast 6 ms conversion.
// - Power-on limits alarm above 147 C critical and 64 C upper.
// - Results compare with critical, upper and lower limits driving alerts.
// - Alert polarity and comparator or interrupt behaviour are configurable.
// - Mode code 01 does one conversion, after a 1 ms wake if shut down, then shuts down.
// - Rewriting the one-shot code starts a fresh single conversion.
// - In interrupt behaviour any register read deasserts both alerts.
// - One-shot comparator overtemp alert clears on a mode write.
// - One-shot comparator critical alert clears on a one-shot write.
// - Mode code 10 converts 60 ms then idles 940 ms each second.
// - Code 11 shuts down; code 00 wakes after 1 ms.
// - Shutdown keeps the last result readable.
// - Leaving shutdown restarts the timing and begins a conversion.
// - Alerts need one more consecutive faulty conversion than the programmed queue depth.
// - A good conversion resets the fault counter to zero.
// - LSB weighs 0.0625 C in 13-bit, 0.0078 C in 16-bit.
// - 13-bit format holds temperature in bits 15..3, flags below.
// - Configuration bit 7 selects 16-bit results; default is 13-bit.
// - 13-bit flags: bit 0 below lower, 1 above upper, 2 critical.
// - Reading the temperature high byte advances the pointer to low byte.
`timescale 1ns/1ps
`default_nettype none

module temp_conv_ctrl import temp_conv_pkg::*; #(
    parameter int FAST_CYCLES = FAST_CYC,
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int SPS_CONV_CYCLES = SPS_CONV_CYC,
    parameter int SPS_IDLE_CYCLES = SPS_IDLE_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wr_stb,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic ptr_wr,
    input wire logic [7:0] ptr_val,
    input wire logic rd_stb,
    input wire logic [15:0] afe_code,
    output logic [7:0] rd_data,
    output logic [15:0] temp_value,
    output logic overtemp_alert_out_oe_n,
    output logic critical_alert_out_oe_n
);
    typedef enum logic [1:0] {ST_WAKE, ST_CONV, ST_WAIT, ST_OFF} st_t;

    st_t st_q, st_d;
    logic boot_q, boot_d;
    logic [7:0] cfg_q, cfg_d, ptr_q, ptr_d, rd_q, rd_d;
    logic [LIM_BYTES-1:0][7:0] lim_q, lim_d;
    logic [15:0] afe_s1_q, afe_s2_q, res_q, res_d, temp_q, temp_d;
    logic [1:0] alert_q, alert_d, oe_n_q, oe_n_d;
    logic [1:0] ok, trip, pol, clr_wr;
    op_mode_t mode, new_mode;
    logic cfg_hit, restart, conv_done, wide, irq_mode, oneshot;
    logic over_hi, under_lo, over_cr;
    logic [15:0] cur, curm, upm, lom, crm;
    logic [16:0] hyst17;

    tmr_if tmr ();
    fq_if fq [2] ();

    function automatic logic [TMR_W-1:0] conv_len(op_mode_t m);
        return (m == MODE_SPS) ? TMR_W'(SPS_CONV_CYCLES)
                               : TMR_W'(CONV_CYCLES);
    endfunction

    // In 13-bit format the three low bits carry no temperature.
    function automatic logic [15:0] fmt(logic [15:0] v, logic w);
        return w ? v : {v[15:FLAG_W], FLAG_W'(0)};
    endfunction

    function automatic logic signed [16:0] sx(logic [15:0] v);
        return $signed({v[15], v});
    endfunction

    function automatic logic [7:0] reg_byte(logic [7:0] a);
        logic [7:0] b;
        b = 8'h00;
        if (a == ADDR_TEMP_MSB) begin
            b = temp_q[15:8];
        end else if (a == ADDR_TEMP_LSB) begin
            b = temp_q[7:0];
        end else if (a == ADDR_CFG) begin
            b = cfg_q;
        end else if (a >= ADDR_LIM_FIRST && a <= ADDR_LIM_LAST) begin
            b = lim_q[3'(a - ADDR_LIM_FIRST)];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Front-end sampling. The code comes from the analog domain, so it
    // crosses two flops; it must be stable around the end of a conversion.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            afe_s1_q <= 16'h0000;
            afe_s2_q <= 16'h0000;
        end else if (ce) begin
            afe_s1_q <= afe_code;
            afe_s2_q <= afe_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.
    assign mode = op_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
    assign new_mode = op_mode_t'(wr_data[CFG_MODE_LSB +: 2]);
    assign cfg_hit = wr_stb && (wr_addr == ADDR_CFG);
    assign restart = cfg_hit
        && (new_mode != mode || new_mode == MODE_ONESHOT);
    assign conv_done = (st_q == ST_CONV) && tmr.done && !restart && !boot_q;

    always_comb begin
        st_d = st_q;
        boot_d = 1'b0;
        tmr.start = 1'b0;
        tmr.load = '0;
        if (boot_q) begin
            st_d = ST_CONV;
            tmr.start = 1'b1;
            tmr.load = TMR_W'(FAST_CYCLES);
        end else if (restart) begin
            if (new_mode == MODE_SHDN) begin
                st_d = ST_OFF;
            end else if (st_q == ST_OFF || st_q == ST_WAKE) begin
                st_d = ST_WAKE;
                tmr.start = 1'b1;
                tmr.load = TMR_W'(WAKE_CYCLES);
            end else begin
                st_d = ST_CONV;
                tmr.start = 1'b1;
                tmr.load = conv_len(new_mode);
            end
        end else begin
            case (st_q)
                ST_WAKE: if (tmr.done) begin
                    st_d = ST_CONV;
                    tmr.start = 1'b1;
                    tmr.load = conv_len(mode);
                end
                ST_CONV: if (tmr.done) begin
                    case (mode)
                        MODE_CONT: begin
                            tmr.start = 1'b1;
                            tmr.load = TMR_W'(CONV_CYCLES);
                        end
                        MODE_SPS: begin
                            st_d = ST_WAIT;
                            tmr.start = 1'b1;
                            tmr.load = TMR_W'(SPS_IDLE_CYCLES);
                        end
                        default: st_d = ST_OFF;
                    endcase
                end
                ST_WAIT: if (tmr.done) begin
                    st_d = ST_CONV;
                    tmr.start = 1'b1;
                    tmr.load = TMR_W'(SPS_CONV_CYCLES);
                end
                ST_OFF: st_d = ST_OFF;
                default: st_d = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_OFF;
            boot_q <= 1'b1;
        end else if (ce) begin
            st_q <= st_d;
            boot_q <= boot_d;
        end
    end

    conv_timer u_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .t(tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register file and read path.
    always_comb begin
        cfg_d = cfg_q;
        lim_d = lim_q;
        ptr_d = ptr_q;
        rd_d = rd_q;
        if (wr_stb) begin
            if (wr_addr == ADDR_CFG) begin
                cfg_d = wr_data;
            end
            for (int j = 0; j < LIM_BYTES; j++) begin
                if (wr_addr == ADDR_LIM_FIRST + 8'(j)) begin
                    lim_d[j] = wr_data;
                end
            end
        end
        if (ptr_wr) begin
            ptr_d = ptr_val;
        end else if (rd_stb) begin
            rd_d = reg_byte(ptr_q);
            if (ptr_q == ADDR_TEMP_MSB) begin
                ptr_d = ADDR_TEMP_LSB;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= CFG_RESET;
            lim_q <= LIM_RESET;
            ptr_q <= ADDR_TEMP_MSB;
            rd_q <= 8'h00;
        end else if (ce) begin
            cfg_q <= cfg_d;
            lim_q <= lim_d;
            ptr_q <= ptr_d;
            rd_q <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit comparison and result formatting.
    assign wide = cfg_q[CFG_RES];
    assign cur = conv_done ? afe_s2_q : res_q;
    assign curm = fmt(cur, wide);
    assign upm = fmt({lim_q[LIM_UP_MSB], lim_q[LIM_UP_LSB]}, wide);
    assign lom = fmt({lim_q[LIM_LO_MSB], lim_q[LIM_LO_LSB]}, wide);
    assign crm = fmt({lim_q[LIM_CR_MSB], lim_q[LIM_CR_LSB]}, wide);
    // Hysteresis is whole degrees, 128 LSBs of the 16-bit code each.
    assign hyst17 = {6'h00, lim_q[LIM_HYST][HYST_W-1:0], 7'h00};
    assign over_hi = sx(curm) > sx(upm);
    assign under_lo = sx(curm) < sx(lom);
    assign over_cr = sx(curm) > sx(crm);
    assign ok[0] = (sx(curm) < $signed(sx(upm) - hyst17))
        && (sx(curm) > $signed(sx(lom) + hyst17));
    assign ok[1] = sx(curm) < $signed(sx(crm) - hyst17);

    always_comb begin
        res_d = res_q;
        temp_d = temp_q;
        if (conv_done) begin
            res_d = afe_s2_q;
            temp_d = wide ? afe_s2_q : fmt(afe_s2_q, 1'b0);
            if (!wide) begin
                temp_d[FLAG_LOW] = under_lo;
                temp_d[FLAG_HIGH] = over_hi;
                temp_d[FLAG_CRIT] = over_cr;
            end
        end
    end

    // Results only move on a finished conversion, so shutdown keeps them.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_q <= 16'h0000;
            temp_q <= 16'h0000;
        end else if (ce) begin
            res_q <= res_d;
            temp_q <= temp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault queues and alert outputs; channel 0 overtemp, channel 1 critical.
    for (genvar g = 0; g < 2; g++) begin : g_fq
        fault_queue u_fq (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .ce(ce),
            .f(fq[g])
        );
        assign fq[g].eval = conv_done;
        assign fq[g].depth = cfg_q[CFG_FQ_LSB +: CFG_FQ_W];
    end
    assign fq[0].fault = over_hi || under_lo;
    assign fq[1].fault = over_cr;
    assign trip = {fq[1].trip, fq[0].trip};
    assign pol = {cfg_q[CFG_CRIT_POL], cfg_q[CFG_INT_POL]};
    assign irq_mode = cfg_q[CFG_IRQ_MODE];
    assign oneshot = (mode == MODE_ONESHOT) || (mode == MODE_SHDN);
    assign clr_wr[0] = cfg_hit;
    assign clr_wr[1] = cfg_hit && (new_mode == MODE_ONESHOT);

    // A trip in the clearing cycle wins, so no fault event is lost.
    always_comb begin
        alert_d = alert_q;
        oe_n_d = oe_n_q;
        for (int i = 0; i < 2; i++) begin
            if (irq_mode) begin
                if (rd_stb) begin
                    alert_d[i] = 1'b0;
                end
            end else if (oneshot) begin
                if (clr_wr[i] && ok[i]) begin
                    alert_d[i] = 1'b0;
                end
            end else if (conv_done && ok[i]) begin
                alert_d[i] = 1'b0;
            end
            if (trip[i]) begin
                alert_d[i] = 1'b1;
            end
            oe_n_d[i] = ~(alert_d[i] ^ pol[i]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            alert_q <= 2'h0;
            oe_n_q <= 2'h3;
        end else if (ce) begin
            alert_q <= alert_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign rd_data = rd_q;
    assign temp_value = temp_q;
    assign overtemp_alert_out_oe_n = oe_n_q[0];
    assign critical_alert_out_oe_n = oe_n_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_fast_first: assert property (boot_q && ce |-> tmr.start
        && tmr.load == TMR_W'(FAST_CYCLES) ##1 st_q == ST_CONV)
        else $error("first conversion is not the fast one");
    a_cont_back: assert property (conv_done && mode == MODE_CONT |->
        tmr.start && tmr.load == TMR_W'(CONV_CYCLES))
        else $error("continuous mode did not restart conversion");
    a_result_store: assert property (conv_done && ce |=>
        res_q == $past(afe_s2_q))
        else $error("conversion result not stored");
    a_oneshot_stop: assert property (
        conv_done && ce && mode == MODE_ONESHOT |=> st_q == ST_OFF)
        else $error("one-shot did not stop after its conversion");
    a_sps_idle: assert property (conv_done && mode == MODE_SPS |->
        tmr.load == TMR_W'(SPS_IDLE_CYCLES) ##1 st_q == ST_WAIT)
        else $error("one per second mode did not idle");
    a_wake_time: assert property (restart && st_q == ST_OFF && !boot_q
        && new_mode == MODE_CONT |-> tmr.load == TMR_W'(WAKE_CYCLES))
        else $error("wake-up from shutdown not timed");
    a_shdn_hold: assert property (st_q == ST_OFF ##1 st_q == ST_OFF
        |-> $stable(temp_q))
        else $error("result changed in shutdown");
    a_irq_clear: assert property (irq_mode && rd_stb && ce
        && trip == 2'h0 |=> alert_q == 2'h0)
        else $error("read did not clear alerts in interrupt mode");
    a_ptr_step: assert property (rd_stb && !ptr_wr && ce
        && ptr_q == ADDR_TEMP_MSB |=> ptr_q == ADDR_TEMP_LSB)
        else $error("pointer did not advance to low byte");
    // The pin follows the alert with the polarity of the previous cycle.
    a_pin_drive: assert property (alert_q[1] && !$past(pol[1]) |->
        critical_alert_out_oe_n == 1'b0)
        else $error("active-low critical alert not driven");
    a_crit_wclear: assert property (oneshot && !irq_mode && ce
        && clr_wr[1] && ok[1] && !trip[1] |=> !alert_q[1])
        else $error("one-shot write did not clear critical alert");

    c_sps_done: cover property (conv_done && mode == MODE_SPS);
    c_irq_read: cover property (alert_q[1] && irq_mode && rd_stb);
    c_wake: cover property (restart && st_q == ST_OFF);
endmodule

`default_nettype wire

//--- verif/host_model.sv
// Host side model: register writes, pointer loads and register reads.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] rd_data,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic ptr_wr,
    output logic [7:0] ptr_val,
    output logic rd_stb
);
    initial begin
        wr_stb = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        ptr_wr = 1'b0;
        ptr_val = 8'h00;
        rd_stb = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One byte write, held for exactly one sampling edge.
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        wr_stb = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge ref_clk);
        #1;
        wr_stb = 1'b0;
    endtask

    // Two-byte temperature read: the pointer is loaded once only.
    task automatic rd_temp(output logic [7:0] msb, output logic [7:0] lsb);
        @(posedge ref_clk);
        #1;
        ptr_wr = 1'b1;
        ptr_val = 8'h00;
        @(posedge ref_clk);
        #1;
        ptr_wr = 1'b0;
        rd_stb = 1'b1;
        @(posedge ref_clk);
        #1;
        msb = rd_data;
        @(posedge ref_clk);
        #1;
        rd_stb = 1'b0;
        lsb = rd_data;
    endtask
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench of the temperature conversion controller.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import temp_conv_pkg::*;

    localparam int FAST = 20;
    localparam int CONV = 40;
    localparam int SPSC = 30;
    localparam int SPSI = 50;
    localparam int WAKE = 10;

    logic ref_clk;
    logic rst_b;
    logic wr_stb, ptr_wr, rd_stb;
    logic [7:0] wr_addr, wr_data, ptr_val, rd_data, msb, lsb;
    logic [15:0] afe_code, temp_value;
    logic ot_oe_n, cr_oe_n;
    int failures;
    int comparisons;
    int n;

    temp_conv_ctrl #(.FAST_CYCLES(FAST), .CONV_CYCLES(CONV),
        .SPS_CONV_CYCLES(SPSC), .SPS_IDLE_CYCLES(SPSI),
        .WAKE_CYCLES(WAKE)) i_temp_conv_ctrl (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .ptr_wr(ptr_wr),
        .ptr_val(ptr_val), .rd_stb(rd_stb), .afe_code(afe_code),
        .rd_data(rd_data), .temp_value(temp_value),
        .overtemp_alert_out_oe_n(ot_oe_n), .critical_alert_out_oe_n(cr_oe_n));

    host_model i_host_model (.ref_clk(ref_clk), .rd_data(rd_data),
        .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
        .ptr_wr(ptr_wr), .ptr_val(ptr_val), .rd_stb(rd_stb));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait for a stored result; a hang ends the run as a failure.
    task automatic wait_temp(input logic [15:0] exp, input int max,
                             output int cnt);
        for (cnt = 1; cnt <= max; cnt++) begin
            @(posedge ref_clk);
            #1;
            if (temp_value === exp) return;
        end
        failures++;
        $display("[FAIL] temp_value expected %h seen %h", exp, temp_value);
        finish_test();
    endtask

    task automatic cfg(input logic [7:0] d);
        i_host_model.wr_byte(ADDR_CFG, d);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        comparisons = 0;
        rst_b = 1'b0;
        afe_code = 16'h2300;
        repeat (20) @(posedge ref_clk);
        #1;
        check("reset temp", temp_value, 16'h0000);
        check("reset alert", ot_oe_n, 1'b1);
        rst_b = 1'b1;
        wait_temp(16'h2302, FAST + 5, n);
        check("fast length", n >= FAST - 1 && n <= FAST + 4, 1'b1);
        check("over alert", ot_oe_n, 1'b0);
        check("crit idle", cr_oe_n, 1'b1);
        afe_code = 16'h0c80;
        wait_temp(16'h0c80, CONV + 5, n);
        check("conv length", n >= CONV - 2, 1'b1);
        check("over clear", ot_oe_n, 1'b1);
        $display("test power-up and continuous done");
        cfg(8'h80);
        afe_code = 16'h0c85;
        wait_temp(16'h0c85, CONV + 5, n);
        i_host_model.rd_temp(msb, lsb);
        check("read msb", msb, 8'h0c);
        check("read lsb", lsb, 8'h85);
        $display("test 16-bit read done");
        cfg(8'h81);
        afe_code = 16'h2300;
        wait_temp(16'h2300, CONV + 5, n);
        check("queue one", ot_oe_n, 1'b1);
        afe_code = 16'h0c80;
        wait_temp(16'h0c80, CONV + 5, n);
        afe_code = 16'h2300;
        wait_temp(16'h2300, CONV + 5, n);
        check("queue reset", ot_oe_n, 1'b1);
        afe_code = 16'h2301;
        wait_temp(16'h2301, CONV + 5, n);
        check("queue two", ot_oe_n, 1'b0);
        $display("test fault queue done");
        cfg(8'h91);
        afe_code = 16'h2300;
        wait_temp(16'h2300, CONV + 5, n);
        check("irq trip", ot_oe_n, 1'b0);
        i_host_model.rd_temp(msb, lsb);
        @(posedge ref_clk);
        #1;
        check("irq read clear", ot_oe_n, 1'b1);
        $display("test interrupt done");
        cfg(8'h80);
        afe_code = 16'h4b00;
        wait_temp(16'h4b00, CONV + 5, n);
        check("crit trip", cr_oe_n, 1'b0);
        cfg(8'he0);
        afe_code = 16'h0c80;
        repeat (CONV + 10) @(posedge ref_clk);
        #1;
        check("shutdown hold", temp_value, 16'h4b00);
        cfg(8'h80);
        wait_temp(16'h0c80, WAKE + CONV + 5, n);
        check("wake length", n >= WAKE + CONV - 1, 1'b1);
        check("crit clear", cr_oe_n, 1'b1);
        $display("test shutdown done");
        cfg(8'ha0);
        afe_code = 16'h2000;
        wait_temp(16'h2000, CONV + 5, n);
        check("abort length", n >= CONV - 1, 1'b1);
        afe_code = 16'h1000;
        repeat (2 * CONV) @(posedge ref_clk);
        #1;
        check("one-shot stops", temp_value, 16'h2000);
        cfg(8'ha0);
        wait_temp(16'h1000, WAKE + CONV + 5, n);
        afe_code = 16'h4b00;
        cfg(8'ha0);
        wait_temp(16'h4b00, WAKE + CONV + 5, n);
        check("one-shot crit", cr_oe_n, 1'b0);
        afe_code = 16'h0c80;
        cfg(8'ha0);
        check("crit hot write", cr_oe_n, 1'b0);
        wait_temp(16'h0c80, WAKE + CONV + 5, n);
        check("crit held", cr_oe_n, 1'b0);
        check("over held", ot_oe_n, 1'b0);
        cfg(8'ha0);
        check("crit write clear", cr_oe_n, 1'b1);
        check("over write clear", ot_oe_n, 1'b1);
        $display("test one-shot done");
        cfg(8'hc0);
        afe_code = 16'h0100;
        wait_temp(16'h0100, WAKE + SPSC + 5, n);
        check("sps conv", n >= WAKE + SPSC - 1, 1'b1);
        afe_code = 16'h0200;
        wait_temp(16'h0200, SPSC + SPSI + 5, n);
        check("sps period", n >= SPSC + SPSI - 2, 1'b1);
        cfg(8'hc4);
        repeat (3) @(posedge ref_clk);
        #1;
        check("crit polarity", cr_oe_n, 1'b0);
        $display("test one per second and polarity done");
        finish_test();
    end
endmodule

`default_nettype wire
